// ---- oivs_params.svh ----
`ifndef OIVS_PARAMS_SVH
`define OIVS_PARAMS_SVH

// status register bit positions
`define OIVS_ST_VBUS_VALID_BIT   1
`define OIVS_ST_SESS_VALID_BIT   2
`define OIVS_ST_SESS_END_BIT     3
`define OIVS_ST_ID_GND_BIT       4
`define OIVS_CK_ID_OPEN_BIT      0

// otg control bit positions
`define OIVS_OTG_ID_BIAS_BIT     0
`define OIVS_OTG_PULLDOWN_BIT    3
`define OIVS_OTG_PULLUP_BIT      4

// edge enable register bit positions (comparator index)
`define OIVS_CMP_VBUS_VALID      0
`define OIVS_CMP_SESS_VALID      1
`define OIVS_CMP_SESS_END        2
`define OIVS_CMP_ID_GND          3
`define OIVS_CMP_ID_OPEN         4
`define OIVS_NUM_CMP             5

// reset values and warm-up done count
`define OIVS_OTG_CTRL_RST        8'h00
`define OIVS_EDGE_EN_RST         5'h00
`define OIVS_EXT_IND_RST         1'b0
`define OIVS_SYNC_RST            1'b0
`define OIVS_WARM_RST            2'h0
`define OIVS_WARM_DONE           2'h3

`endif

// ---- oivs_pkg.sv ----
package oivs_pkg;
  typedef logic [7:0] oivs_reg8_t;
  typedef logic [4:0] oivs_cmp_t;
  typedef enum logic [1:0]
  {
    OIVS_SRC_COMPARATOR,
    OIVS_SRC_FIXED_ONE,
    OIVS_SRC_FIXED_ZERO
  } oivs_vsrc_e;
endpackage

// ---- oivs_sync_edge.sv ----
`include "oivs_params.svh"

module oivs_sync_edge
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // raw comparator output
  input  wire logic async_in,
  // synchronised level and edges
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic       meta_r;
  logic       sync_r;
  logic       prev_r;
  logic [1:0] warm_r;
  logic       warm_ok;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      meta_r <= `OIVS_SYNC_RST;
      sync_r <= `OIVS_SYNC_RST;
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      prev_r <= `OIVS_SYNC_RST;
    else
      prev_r <= sync_r;
  end

  // no edges until the pipeline holds real samples: a comparator
  // already high at reset must not look like a fresh rise
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      warm_r <= `OIVS_WARM_RST;
    else if (warm_r != `OIVS_WARM_DONE)
      warm_r <= warm_r + 2'h1;
  end

  // one edge per transition
  // level moves with the edge so an rx command carries the new state
  assign warm_ok = (warm_r == `OIVS_WARM_DONE);
  assign level   = sync_r;
  assign rise    = sync_r & ~prev_r & warm_ok;
  assign fall    = ~sync_r & prev_r & warm_ok;
endmodule // oivs_sync_edge

// ---- oivs_vsrc_sel.sv ----
`include "oivs_params.svh"

module oivs_vsrc_sel
  import oivs_pkg::*;
(
  // selection controls
  input  wire logic use_ext_ind,
  input  wire logic ind_pass_thru,
  input  wire logic ind_complement,
  // comparator level
  input  wire logic vbus_cmp,
  // chosen source and value
  output oivs_vsrc_e src,
  output logic       vbus_rx
);
  // external indicator is tied high inside the device
  localparam logic EXT_IND = 1'b1;

  always_comb
  begin
    if (!use_ext_ind)
      src = OIVS_SRC_COMPARATOR;
    else if (ind_complement)
      src = OIVS_SRC_FIXED_ZERO;
    else if (ind_pass_thru)
      src = OIVS_SRC_FIXED_ONE;
    else
      src = OIVS_SRC_COMPARATOR;
  end

  always_comb
  begin
    case (src)
      OIVS_SRC_COMPARATOR: vbus_rx = vbus_cmp;
      OIVS_SRC_FIXED_ONE:  vbus_rx = EXT_IND;
      OIVS_SRC_FIXED_ZERO: vbus_rx = 1'b0;
      default:             vbus_rx = 1'b0;
    endcase
  end
endmodule // oivs_vsrc_sel

// ---- oivs_top.sv ----
`include "oivs_params.svh"

module oivs_top
  import oivs_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // analog comparator outputs
  input  wire logic cmp_id_grounded,
  input  wire logic cmp_id_open,
  input  wire logic cmp_session_end,
  input  wire logic cmp_session_valid,
  input  wire logic cmp_vbus_valid,
  // control from the link
  input  wire logic id_bias_resistor_enable,
  input  wire logic vbus_pulldown_enable,
  input  wire logic vbus_pullup_enable,
  input  wire logic [4:0] rise_irq_en,
  input  wire logic [4:0] fall_irq_en,
  input  wire logic external_vbus_ind_select,
  input  wire logic ind_pass_thru,
  input  wire logic ind_complement,
  // analog switch controls
  output logic      id_pullup_on,
  output logic      vbus_pulldown_on,
  output logic      vbus_pullup_on,
  // status views
  output logic [7:0] usb_irq_status,
  output logic [7:0] carkit_irq_status,
  output logic [7:0] otg_control,
  output logic       id_grounded_flag,
  output logic       id_open_flag,
  output logic       session_end_flag,
  output logic       session_valid_flag,
  output logic       vbus_valid_flag,
  // receive command toward the link
  output logic       rxcmd_req,
  output logic       rxcmd_alt_int,
  output logic       rxcmd_vbus_valid,
  output logic       rxcmd_sess_valid,
  output logic       rxcmd_sess_end,
  // interrupt event pulse
  output logic       irq_event
);
  oivs_cmp_t  raw;
  oivs_cmp_t  lvl;
  oivs_cmp_t  rise;
  oivs_cmp_t  fall;
  oivs_cmp_t  cmp_on;
  oivs_cmp_t  irq_hit;
  logic       vbus_rx;
  logic       rx_any_nxt;
  logic       alt_nxt;
  logic       irq_nxt;
  logic [7:0] usb_st_nxt;
  logic [7:0] ck_st_nxt;
  logic [7:0] otg_nxt;

  assign raw[`OIVS_CMP_VBUS_VALID] = cmp_vbus_valid;
  assign raw[`OIVS_CMP_SESS_VALID] = cmp_session_valid;
  assign raw[`OIVS_CMP_SESS_END]   = cmp_session_end;
  assign raw[`OIVS_CMP_ID_GND]     = cmp_id_grounded;
  assign raw[`OIVS_CMP_ID_OPEN]    = cmp_id_open;

  genvar g;
  generate
    for (g = 0; g < `OIVS_NUM_CMP; g++)
    begin : g_cmp
      oivs_sync_edge u_sync
      (
        .core_clk (core_clk),
        .reset    (reset),
        .async_in (raw[g]),
        .level    (lvl[g]),
        .rise     (rise[g]),
        .fall     (fall[g])
      );
    end
  endgenerate

  oivs_vsrc_sel u_vsrc
  (
    .use_ext_ind    (external_vbus_ind_select),
    .ind_pass_thru  (ind_pass_thru),
    .ind_complement (ind_complement),
    .vbus_cmp       (lvl[`OIVS_CMP_VBUS_VALID]),
    .src            (),
    .vbus_rx        (vbus_rx)
  );

  // comparator counts as disabled with both enables clear
  assign cmp_on = rise_irq_en | fall_irq_en;
  assign irq_hit = (rise & rise_irq_en) | (fall & fall_irq_en);

  always_comb
  begin
    usb_st_nxt = 8'h00;
    usb_st_nxt[`OIVS_ST_VBUS_VALID_BIT] =
      lvl[`OIVS_CMP_VBUS_VALID] & cmp_on[`OIVS_CMP_VBUS_VALID];
    usb_st_nxt[`OIVS_ST_SESS_VALID_BIT] = lvl[`OIVS_CMP_SESS_VALID];
    usb_st_nxt[`OIVS_ST_SESS_END_BIT] =
      lvl[`OIVS_CMP_SESS_END] & cmp_on[`OIVS_CMP_SESS_END];
    usb_st_nxt[`OIVS_ST_ID_GND_BIT] = lvl[`OIVS_CMP_ID_GND];
  end

  always_comb
  begin
    ck_st_nxt = 8'h00;
    ck_st_nxt[`OIVS_CK_ID_OPEN_BIT] = lvl[`OIVS_CMP_ID_OPEN];
  end

  always_comb
  begin
    otg_nxt = 8'h00;
    otg_nxt[`OIVS_OTG_ID_BIAS_BIT] = id_bias_resistor_enable;
    otg_nxt[`OIVS_OTG_PULLDOWN_BIT] = vbus_pulldown_enable;
    otg_nxt[`OIVS_OTG_PULLUP_BIT] = vbus_pullup_enable;
  end

  // session valid change always commands; others when enabled
  assign rx_any_nxt = rise[`OIVS_CMP_SESS_VALID]
                    | fall[`OIVS_CMP_SESS_VALID]
                    | (|irq_hit);
  assign alt_nxt = irq_hit[`OIVS_CMP_ID_OPEN];
  assign irq_nxt = |irq_hit;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      usb_irq_status    <= 8'h00;
      carkit_irq_status <= 8'h00;
    end
    else
    begin
      usb_irq_status    <= usb_st_nxt;
      carkit_irq_status <= ck_st_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      otg_control      <= `OIVS_OTG_CTRL_RST;
      id_pullup_on     <= 1'b0;
      vbus_pulldown_on <= 1'b0;
      vbus_pullup_on   <= 1'b0;
    end
    else
    begin
      otg_control      <= otg_nxt;
      id_pullup_on     <= id_bias_resistor_enable;
      vbus_pulldown_on <= vbus_pulldown_enable;
      vbus_pullup_on   <= vbus_pullup_enable;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      rxcmd_req        <= 1'b0;
      rxcmd_alt_int    <= 1'b0;
      rxcmd_vbus_valid <= 1'b0;
      rxcmd_sess_valid <= 1'b0;
      rxcmd_sess_end   <= 1'b0;
      irq_event        <= 1'b0;
    end
    else
    begin
      rxcmd_req        <= rx_any_nxt;
      rxcmd_alt_int    <= alt_nxt;
      rxcmd_vbus_valid <= vbus_rx;
      rxcmd_sess_valid <= lvl[`OIVS_CMP_SESS_VALID];
      rxcmd_sess_end   <= usb_st_nxt[`OIVS_ST_SESS_END_BIT];
      irq_event        <= irq_nxt;
    end
  end

  assign id_grounded_flag   = usb_irq_status[`OIVS_ST_ID_GND_BIT];
  assign id_open_flag       = carkit_irq_status[`OIVS_CK_ID_OPEN_BIT];
  assign session_end_flag   = usb_irq_status[`OIVS_ST_SESS_END_BIT];
  assign session_valid_flag = usb_irq_status[`OIVS_ST_SESS_VALID_BIT];
  assign vbus_valid_flag    = usb_irq_status[`OIVS_ST_VBUS_VALID_BIT];
endmodule // oivs_top

// ---- oivs_top_sva.sv ----
`include "oivs_params.svh"

module oivs_top_sva
(
  // clock and reset
  input wire logic       core_clk,
  input wire logic       reset,
  // link controls and raw level
  input wire logic       cmp_session_valid,
  input wire logic       cmp_id_grounded,
  input wire logic       cmp_id_open,
  input wire logic       id_bias_resistor_enable,
  input wire logic       vbus_pulldown_enable,
  input wire logic       vbus_pullup_enable,
  input wire logic [4:0] rise_irq_en,
  input wire logic [4:0] fall_irq_en,
  // design outputs
  input wire logic       id_pullup_on,
  input wire logic       vbus_pulldown_on,
  input wire logic       vbus_pullup_on,
  input wire logic [7:0] usb_irq_status,
  input wire logic [7:0] carkit_irq_status,
  input wire logic       id_grounded_flag,
  input wire logic       id_open_flag,
  input wire logic       session_end_flag,
  input wire logic       rxcmd_req,
  input wire logic       rxcmd_alt_int,
  input wire logic       irq_event
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  bias_follow_a: assert property
    (id_pullup_on == $past(id_bias_resistor_enable))
    else $error("id pull-up control lags its enable wrongly");
  alt_has_req_a: assert property (rxcmd_alt_int |-> rxcmd_req)
    else $error("alt interrupt without receive command");
  gnd_bit4_a: assert property
    (usb_irq_status[4] == $past(cmp_id_grounded, 3)
      && id_grounded_flag == usb_irq_status[4])
    else $error("id grounded flag not in status bit 4");
  open_bit0_a: assert property
    (carkit_irq_status[0] == $past(cmp_id_open, 3)
      && id_open_flag == carkit_irq_status[0])
    else $error("id open flag not in carkit bit 0");
  sess_end_off_a: assert property
    (!$past(rise_irq_en[2]) && !$past(fall_irq_en[2]) |-> !session_end_flag)
    else $error("disabled session end reads one");
  vbus_off_a: assert property
    (!$past(rise_irq_en[0]) && !$past(fall_irq_en[0])
      |-> !usb_irq_status[`OIVS_ST_VBUS_VALID_BIT])
    else $error("disabled vbus valid reads one");
  sess_rxcmd_a: assert property
    ($changed(cmp_session_valid) |-> ##[2:5] rxcmd_req)
    else $error("session valid change gave no receive command");
  pulldown_a: assert property
    (vbus_pulldown_on == $past(vbus_pulldown_enable))
    else $error("vbus pull-down control wrong");
  pullup_a: assert property
    (vbus_pullup_on == $past(vbus_pullup_enable))
    else $error("vbus pull-up control wrong");

  cover property (rxcmd_alt_int);
  cover property (irq_event);
  cover property (rxcmd_req && !rxcmd_alt_int);
endmodule // oivs_top_sva

// ---- oivs_link_model.sv ----
module oivs_link_model
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // from the device
  input  wire logic rxcmd_req,
  input  wire logic rxcmd_alt_int,
  input  wire logic irq_event,
  input  wire logic session_valid_flag,
  // link view
  output int        n_rx,
  output int        n_alt,
  output int        n_irq,
  output logic      vbus_seen
);
  assign vbus_seen = session_valid_flag;

  always_ff @(posedge core_clk or posedge reset)
    if (reset)
    begin
      n_rx  <= 0;
      n_alt <= 0;
      n_irq <= 0;
    end
    else
    begin
      n_rx  <= n_rx + int'(rxcmd_req);
      n_alt <= n_alt + int'(rxcmd_alt_int);
      n_irq <= n_irq + int'(irq_event);
    end
endmodule // oivs_link_model

// ---- oivs_top_tb_top.sv ----
module oivs_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk = 1'b0;
  logic       reset = 1'b1;
  logic [4:0] cmp = 5'h00, re = 5'h00, fe = 5'h00;
  logic       bias = 0, pd = 0, pu = 0, sel = 0, pass = 0, inv = 0;
  logic       id_pullup_on, vbus_pulldown_on, vbus_pullup_on, irq_event;
  logic [7:0] usb_irq_status, carkit_irq_status, otg_control;
  logic       id_grounded_flag, id_open_flag, session_end_flag;
  logic       session_valid_flag, vbus_valid_flag, rxcmd_req, rxcmd_alt_int;
  logic       rxcmd_vbus_valid, rxcmd_sess_valid, rxcmd_sess_end, vbus_seen;
  int         n_rx, n_alt, n_irq, err_count = 0, n_tests = 0, seed = 7;

  always #5 core_clk = ~core_clk;

  oivs_top i_oivs_top (.core_clk, .reset, .cmp_vbus_valid(cmp[0]),
    .cmp_session_valid(cmp[1]), .cmp_session_end(cmp[2]),
    .cmp_id_grounded(cmp[3]), .cmp_id_open(cmp[4]),
    .id_bias_resistor_enable(bias), .vbus_pulldown_enable(pd),
    .vbus_pullup_enable(pu), .rise_irq_en(re), .fall_irq_en(fe),
    .external_vbus_ind_select(sel), .ind_pass_thru(pass),
    .ind_complement(inv), .id_pullup_on, .vbus_pulldown_on,
    .vbus_pullup_on, .usb_irq_status, .carkit_irq_status, .otg_control,
    .id_grounded_flag, .id_open_flag, .session_end_flag,
    .session_valid_flag, .vbus_valid_flag, .rxcmd_req, .rxcmd_alt_int,
    .rxcmd_vbus_valid, .rxcmd_sess_valid, .rxcmd_sess_end, .irq_event);

  oivs_link_model i_oivs_link_model (.core_clk, .reset, .rxcmd_req,
    .rxcmd_alt_int, .irq_event, .session_valid_flag, .n_rx, .n_alt,
    .n_irq, .vbus_seen);

  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    $display("mismatches %0d of %0d compares", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (100000) @(posedge core_clk);
    err_count++;
    end_of_test;
  end

  initial
  begin
    logic [31:0] r;
    int          k, rx0, e_alt, e_irq;
    logic        v, ev, hit, g0, g2;
    e_alt = 0;
    e_irq = 0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    // bias on, settle wait shortened for run time
    bias   <= 1'b1;
    cmp[3] <= 1'b1;
    repeat (20) @(posedge core_clk);
    check(id_grounded_flag, 1'b1);
    for (int i = 0; i < 80; i++)
    begin
      r = $random(seed);
      // bias off, only session valid enabled
      if (i % 10 == 9)
      begin
        r[5]     = 1'b0;
        r[12:8]  = 5'h02;
        r[20:16] = 5'h02;
      end
      {bias, pd, pu, sel, pass, inv} <= r[5:0];
      re <= r[12:8];
      fe <= r[20:16];
      repeat (3) @(posedge core_clk);
      k = {$random(seed)} % 5;
      v = ~cmp[k];
      rx0 = n_rx;
      cmp[k] <= v;
      hit = v ? re[k] : fe[k];
      if (hit)
        e_irq++;
      if (k == 4 && hit)
        e_alt++;
      repeat (8) @(posedge core_clk);
      g0 = cmp[0] & (re[0] | fe[0]);
      g2 = cmp[2] & (re[2] | fe[2]);
      check(id_pullup_on, bias);
      check(otg_control, {3'h0, pu, pd, 2'h0, bias});
      check({vbus_pulldown_on, vbus_pullup_on}, {pd, pu});
      check({id_grounded_flag, id_open_flag}, {cmp[3], cmp[4]});
      check(usb_irq_status, {3'h0, cmp[3], g2, cmp[1], g0, 1'b0});
      check({vbus_valid_flag, session_end_flag}, {g0, g2});
      check(rxcmd_sess_end, g2);
      check(carkit_irq_status, {7'h0, cmp[4]});
      check({session_valid_flag, rxcmd_sess_valid}, {2{cmp[1]}});
      check(vbus_seen, cmp[1]);
      check(8'(n_irq), 8'(e_irq));
      check(8'(n_alt), 8'(e_alt));
      check(8'(n_rx - rx0), 8'(hit | (k == 1)));
      ev = sel ? (pass ? !inv : !inv & cmp[0]) : cmp[0];
      check(rxcmd_vbus_valid, ev);
    end
    end_of_test;
  end
endmodule // oivs_top_tb_top

bind oivs_top oivs_top_sva i_oivs_top_sva (.core_clk, .reset,
  .cmp_session_valid, .cmp_id_grounded, .cmp_id_open,
  .id_bias_resistor_enable, .vbus_pulldown_enable,
  .vbus_pullup_enable, .rise_irq_en, .fall_irq_en, .id_pullup_on,
  .vbus_pulldown_on, .vbus_pullup_on, .usb_irq_status, .carkit_irq_status,
  .id_grounded_flag, .id_open_flag, .session_end_flag, .rxcmd_req,
  .rxcmd_alt_int, .irq_event);
